// file: include/fsq_pkg.sv
package fsq_pkg;
  // Command codes written on the low data byte
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_CHIP_SETUP   = 8'h30;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h01;
  localparam logic [7:0] CMD_LOCK_PERM    = 8'hF1;
  // Status bit positions
  localparam int MACHINE_READY_POS  = 7;
  localparam int ERASE_FAIL_POS     = 5;
  localparam int LOCK_SET_FAIL_POS  = 4;
  localparam int SUPPLY_FAULT_POS   = 3;
  localparam int PROTECT_HIT_POS    = 1;
  // Bus cycle timing, in clock cycles of 40 ns
  localparam int    CLK_PERIOD_NS  = 40;
  localparam int    WE_PULSE_NS    = 100;
  localparam int    RD_ACCESS_NS   = 120;
  localparam logic [3:0] WE_CYCLES = 4'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RD_CYCLES = 4'((RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // Operations accepted at the user port
  localparam logic [2:0] OP_CHIP_ERASE = 3'h0;
  localparam logic [2:0] OP_LOCK_BLOCK = 3'h1;
  localparam logic [2:0] OP_LOCK_PERM  = 3'h2;
  localparam logic [2:0] OP_CLEAR_LOCK = 3'h3;
  localparam logic [2:0] OP_CLEAR_STAT = 3'h4;
  localparam logic [2:0] OP_READ_ARRAY = 3'h5;
endpackage

// file: rtl/fsq_bus_cycle.sv
`timescale 1ns/1ps
// Performs one timed write or read cycle on the flash pins.
module fsq_bus_cycle (
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire logic                       start_i,
  input  wire logic                       write_i,
  input  wire logic [fsq_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [fsq_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [fsq_pkg::DATA_W-1:0] dq_sync_i,
  output logic                            done_o,
  output logic [fsq_pkg::DATA_W-1:0]      rdata_o,
  output logic                            ce_n_o,
  output logic                            we_n_o,
  output logic                            oe_n_o,
  output logic [fsq_pkg::ADDR_W-1:0]      a_o,
  output logic [fsq_pkg::DATA_W-1:0]      dq_o,
  output logic                            dq_oe_o
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       wr_q;
  // Two extra cycles let read data pass the pin synchroniser
  wire logic [3:0] len_w = write_i ? fsq_pkg::WE_CYCLES : 4'(fsq_pkg::RD_CYCLES + 4'h2);
  wire logic       last_w = busy_q && (cnt_q == 4'h1);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      wr_q    <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= '0;
      ce_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      a_o     <= '0;
      dq_o    <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      done_o <= last_w;
      if (start_i && !busy_q) begin
        busy_q  <= 1'b1;
        cnt_q   <= len_w;
        wr_q    <= write_i;
        a_o     <= addr_i;
        dq_o    <= wdata_i;
        dq_oe_o <= write_i;
        ce_n_o  <= 1'b0;
        we_n_o  <= !write_i;
        oe_n_o  <= write_i;
      end else if (busy_q) begin
        cnt_q <= 4'(cnt_q - 4'h1);
        if (last_w) begin
          busy_q  <= 1'b0;
          ce_n_o  <= 1'b1;
          we_n_o  <= 1'b1;
          oe_n_o  <= 1'b1;
          dq_oe_o <= 1'b0;
          if (!wr_q) begin
            rdata_o <= dq_sync_i;
          end
        end
      end
    end
  end
endmodule

// file: rtl/fsq_host.sv
`timescale 1ns/1ps
// Overview of operation
// - Chip erase: 30H then D0H
// - Lock set: 60H then 01H or F1H
// - Clear locks: 60H then D0H
// - Lock sets may chain before checking; the host polls status to ready after each lock set
// - Clear status after any error; the host leaves this to an OP_CLEAR_STAT request
// - Write FFH after last operation; the host leaves this to an OP_READ_ARRAY request
// - Poll status until ready after confirm
module fsq_host (
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire logic                       req_i,
  input  wire logic [2:0]                 op_i,
  input  wire logic [fsq_pkg::ADDR_W-1:0] addr_i,
  output logic                            ack_o,
  output logic                            busy_o,
  output logic [7:0]                      status_o,
  output logic                            error_o,
  output logic                            seq_error_o,
  output logic                            rb_ready_o,
  output logic                            ce_n_o,
  output logic                            we_n_o,
  output logic                            oe_n_o,
  output logic [fsq_pkg::ADDR_W-1:0]      a_o,
  output logic [fsq_pkg::DATA_W-1:0]      dq_o,
  output logic                            dq_oe_o,
  input  wire logic [fsq_pkg::DATA_W-1:0] dq_i,
  input  wire logic                       ready_busy_out_n_i
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_CONF  = 6'b000100,
    ST_POLL  = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_DONE  = 6'b100000
  } fsq_state_e;

  fsq_state_e state_q;
  fsq_state_e state_d;
  logic [2:0]                 op_q;
  logic [fsq_pkg::ADDR_W-1:0] addr_q;
  logic [fsq_pkg::DATA_W-1:0] dq_m_q;
  logic [fsq_pkg::DATA_W-1:0] dq_s_q;
  logic                       rb_m_q;
  logic                       rb_s_q;
  logic                       start_q;
  logic                       wr_q;
  logic [7:0]                 wdata_q;
  logic                       cyc_done;
  logic [fsq_pkg::DATA_W-1:0] cyc_rdata;

  // Pin inputs pass two flops before any use
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dq_m_q <= '0;
      dq_s_q <= '0;
      rb_m_q <= 1'b1;
      rb_s_q <= 1'b1;
    end else begin
      dq_m_q <= dq_i;
      dq_s_q <= dq_m_q;
      rb_m_q <= ready_busy_out_n_i;
      rb_s_q <= rb_m_q;
    end
  end

  wire logic two_cycle_w = (op_q != fsq_pkg::OP_CLEAR_STAT) && (op_q != fsq_pkg::OP_READ_ARRAY);
  wire logic [7:0] setup_code_w = (op_q == fsq_pkg::OP_CHIP_ERASE) ? fsq_pkg::CMD_CHIP_SETUP :
                                  two_cycle_w ? fsq_pkg::CMD_LOCK_SETUP :
                                  (op_q == fsq_pkg::OP_CLEAR_STAT) ? fsq_pkg::CMD_CLEAR_STATUS :
                                  fsq_pkg::CMD_READ_ARRAY;
  // confirm code picks block or permanent lock
  wire logic [7:0] conf_code_w = (op_q == fsq_pkg::OP_LOCK_BLOCK) ? fsq_pkg::CMD_LOCK_BLOCK :
                                 (op_q == fsq_pkg::OP_LOCK_PERM) ? fsq_pkg::CMD_LOCK_PERM :
                                 fsq_pkg::CMD_CONFIRM;
  // ready bit of last status read
  wire logic ready_w = cyc_rdata[fsq_pkg::MACHINE_READY_POS];
  // both fail bits flag a bad sequence
  wire logic seq_err_w = cyc_rdata[fsq_pkg::ERASE_FAIL_POS] &&
                         cyc_rdata[fsq_pkg::LOCK_SET_FAIL_POS];
  wire logic any_err_w = cyc_rdata[fsq_pkg::ERASE_FAIL_POS] ||
                         cyc_rdata[fsq_pkg::LOCK_SET_FAIL_POS] ||
                         cyc_rdata[fsq_pkg::SUPPLY_FAULT_POS] ||
                         cyc_rdata[fsq_pkg::PROTECT_HIT_POS];

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req_i) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cyc_done) begin
          state_d = two_cycle_w ? ST_CONF : ST_DONE;
        end
      end
      ST_CONF: begin
        if (cyc_done) begin
          state_d = ST_POLL;
        end
      end
      ST_POLL: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (cyc_done) begin
          state_d = ready_w ? ST_DONE : ST_POLL;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  wire logic launch_w = (state_q == ST_IDLE && req_i) ||
                        (state_q == ST_SETUP && cyc_done && two_cycle_w) ||
                        (state_q == ST_POLL);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q     <= ST_IDLE;
      op_q        <= fsq_pkg::OP_CHIP_ERASE;
      addr_q      <= '0;
      start_q     <= 1'b0;
      wr_q        <= 1'b0;
      wdata_q     <= 8'h00;
      ack_o       <= 1'b0;
      busy_o      <= 1'b0;
      status_o    <= 8'h00;
      error_o     <= 1'b0;
      seq_error_o <= 1'b0;
      rb_ready_o  <= 1'b1;
    end else begin
      state_q    <= state_d;
      start_q    <= launch_w;
      ack_o      <= (state_d == ST_DONE);
      busy_o     <= (state_d != ST_IDLE);
      rb_ready_o <= rb_s_q;
      if (state_q == ST_IDLE && req_i) begin
        op_q    <= op_i;
        addr_q  <= addr_i;
        wr_q    <= 1'b1;
        wdata_q <= 8'h00;
      end
      if (state_q == ST_IDLE && req_i) begin
        wdata_q <= 8'h00;
      end else if (state_q == ST_SETUP && cyc_done) begin
        wdata_q <= conf_code_w;
      end
      if (state_q == ST_POLL) begin
        wr_q <= 1'b0;
      end
      if (state_q == ST_WAIT && cyc_done && ready_w) begin
        status_o    <= cyc_rdata[7:0];
        error_o     <= any_err_w;
        seq_error_o <= seq_err_w;
      end
      // clear and array read driven by user
      if (state_q == ST_SETUP && cyc_done && op_q == fsq_pkg::OP_CLEAR_STAT) begin
        status_o    <= 8'h00;
        error_o     <= 1'b0;
        seq_error_o <= 1'b0;
      end
    end
  end

  wire logic [7:0] code_w = (state_q == ST_SETUP && !start_q && !cyc_done && wdata_q == 8'h00)
                            ? setup_code_w : wdata_q;
  wire logic [7:0] cyc_code_w = (state_q == ST_SETUP) ? setup_code_w :
                                (state_q == ST_CONF) ? conf_code_w : code_w;

  fsq_bus_cycle u_cycle (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .start_i   (start_q),
    .write_i   (wr_q && state_q != ST_WAIT),
    .addr_i    (addr_q),
    .wdata_i   ({8'h00, cyc_code_w}),
    .dq_sync_i (dq_s_q),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .ce_n_o    (ce_n_o),
    .we_n_o    (we_n_o),
    .oe_n_o    (oe_n_o),
    .a_o       (a_o),
    .dq_o      (dq_o),
    .dq_oe_o   (dq_oe_o)
  );

  property p_seq_after_setup;
    @(posedge clock_i) disable iff (srst_i)
    (state_q == ST_SETUP && cyc_done && two_cycle_w) |=> (state_q == ST_CONF);
  endproperty
  a_seq_after_setup: assert property (p_seq_after_setup) else $error("no confirm");

  property p_poll_after_conf;
    @(posedge clock_i) disable iff (srst_i)
    (state_q == ST_CONF && cyc_done) |=> (state_q == ST_POLL) ##1 (state_q == ST_WAIT);
  endproperty
  a_poll_after_conf: assert property (p_poll_after_conf) else $error("no poll");

  property p_busy_keeps_poll;
    @(posedge clock_i) disable iff (srst_i)
    (state_q == ST_WAIT && cyc_done && !ready_w) |=> (state_q == ST_POLL);
  endproperty
  a_busy_keeps_poll: assert property (p_busy_keeps_poll) else $error("poll stopped");

  property p_seq_err;
    @(posedge clock_i) disable iff (srst_i)
    (state_q == ST_WAIT && cyc_done && ready_w && seq_err_w) |=> (seq_error_o && error_o);
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("seq error lost");

  property p_ack_pulse;
    @(posedge clock_i) disable iff (srst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not pulse");

  property p_chip_setup_code;
    @(posedge clock_i) disable iff (srst_i)
    (state_q == ST_SETUP && !we_n_o && op_q == fsq_pkg::OP_CHIP_ERASE) |->
      (dq_o == {8'h00, fsq_pkg::CMD_CHIP_SETUP});
  endproperty
  a_chip_setup_code: assert property (p_chip_setup_code) else $error("bad setup code");

  c_chip: cover property (@(posedge clock_i) ack_o && op_q == fsq_pkg::OP_CHIP_ERASE);
  c_lock: cover property (@(posedge clock_i) ack_o && op_q == fsq_pkg::OP_LOCK_PERM);
  c_err:  cover property (@(posedge clock_i) error_o);
endmodule

// file: test/fsq_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash device on the far side of the host pins.
module fsq_flash_model #(
  parameter int          BUSY_NS = 2000,
  parameter logic [15:0] ARRAY_W = 16'hA5C3
) (
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [19:0] a_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        dq_oe_i,
  input  wire logic [4:0]  inj_i,
  output logic [15:0]      dq_o,
  output logic             rb_low_o,
  output logic [15:0]      seq_o,
  output logic [19:0]      conf_a_o,
  output logic             array_o
);
  logic [7:0]  sr = 8'h80;
  logic [7:0]  pend = 8'h00;
  logic [7:0]  c;
  logic [15:0] last = 16'h0000;
  int          ef;
  wire         rd = !ce_n_i && !oe_n_i && !dq_oe_i;
  // A write ends when either strobe rises; the host raises both in one step
  wire         wr_act = !ce_n_i && !we_n_i;
  wire [15:0]  val = array_o ? ARRAY_W : {8'h00, sr};
  // Released lines show the inverse, not a stale word
  assign dq_o = rd ? val : ~last;
  always @(negedge rd) last = val;
  initial begin
    rb_low_o = 1'b0;
    array_o = 1'b1;
    seq_o = 16'h0000;
    conf_a_o = 20'h00000;
  end
  always @(negedge wr_act) begin
    c = dq_i[7:0];
    array_o = (c == 8'hFF);
    ef = (c == 8'h01 || c == 8'hF1) ? 4 : 5;
    if (c == 8'h50) sr[5:1] = 5'h00;
    if (pend != 8'h00) begin
      seq_o = {pend, c};
      conf_a_o = a_i;
      if (inj_i[4] || !((pend == 8'h30 && c == 8'hD0) ||
          (pend == 8'h60 && (c == 8'h01 || c == 8'hF1 || c == 8'hD0)))) begin
        sr[5:4] = 2'h3;
      end else begin
        if (inj_i[3]) sr[3] = 1'b1;
        if (inj_i[3]) sr[ef] = 1'b1;
        if (pend == 8'h30 ? inj_i[2] : (c != 8'hF1 && inj_i[1])) sr[1] = 1'b1;
        if (inj_i[0]) sr[ef] = 1'b1;
      end
      sr[7] = 1'b0;
      rb_low_o = 1'b1;
      pend = 8'h00;
    end else if (c == 8'h30 || c == 8'h60) pend = c;
  end
  always @(negedge sr[7]) begin
    #BUSY_NS;
    sr[7] = 1'b1;
    rb_low_o = 1'b0;
  end
endmodule

// file: test/fsq_host_tb.sv
`timescale 1ns/1ps
module fsq_host_tb;
  typedef struct packed {
    logic [2:0]  op;
    logic [4:0]  inj;
    logic [15:0] seq;
    logic [7:0]  st;
  } fsq_row_s;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        req_i = 1'b0;
  logic [2:0]  op_i = 3'h0;
  logic [19:0] addr_i = 20'h00000;
  logic [4:0]  inj = 5'h00;
  logic        ack, busy, err, seqe, rbr, ce_n, we_n, oe_n, dq_oe, rb_low, arr, saw;
  logic [7:0]  st;
  logic [19:0] a, ca;
  logic [15:0] dq, dqm, mseq;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  // pull-up on the open-drain ready pin
  wire         rb_pin = rb_low ? 1'b0 : 1'b1;
  fsq_row_s rows [17] = '{32'h0030D080, 32'h0430D082, 32'h80000000, 32'h20600180,
    32'h22600182, 32'h4160F192, 32'h80000000, 32'h6260D082, 32'h6860D0AA, 32'h80000000,
    32'h0130D0A0, 32'h80000000, 32'h4860F198, 32'h80000000, 32'h1030D0B0, 32'h80000000,
    32'hA0000000};
  always #20 clock_i = ~clock_i;
  fsq_host uut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .ack_o(ack), .busy_o(busy), .status_o(st), .error_o(err),
    .seq_error_o(seqe), .rb_ready_o(rbr), .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n),
    .a_o(a), .dq_o(dq), .dq_oe_o(dq_oe), .dq_i(dqm), .ready_busy_out_n_i(rb_pin));
  fsq_flash_model dev (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .a_i(a), .dq_i(dq),
    .dq_oe_i(dq_oe), .inj_i(inj), .dq_o(dqm), .rb_low_o(rb_low), .seq_o(mseq),
    .conf_a_o(ca), .array_o(arr));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic do_op(logic [2:0] op, logic [19:0] ad, int hold);
    int n;
    n = 0;
    saw = 1'b0;
    @(posedge clock_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= ad;
    repeat (hold) @(posedge clock_i);
    req_i <= 1'b0;
    while (ack !== 1'b1 && n < 400) begin
      @(posedge clock_i);
      #1;
      n++;
      if (rbr === 1'b0) saw = 1'b1;
    end
    check("ack", 32'(n < 400), 1);
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    check("idle", {busy, ce_n, we_n, dq_oe, rbr}, 5'h0D);
    foreach (rows[i]) begin
      inj = rows[i].inj;
      do_op(rows[i].op, 20'h42000 + 20'(i), 1);
      if (rows[i].st != 8'h00) begin
        check("status", st, rows[i].st);
        check("error", err, |(rows[i].st & 8'h3A));
        check("seq_error", seqe, &rows[i].st[5:4]);
        check("bus_codes", mseq, rows[i].seq);
        check("pin_busy", saw, 1);
      end
      if (rows[i].op == 3'h1) check("lock_addr", ca, 20'h42000 + 20'(i));
    end
    check("array_mode", arr, 1);
    inj = 5'h00;
    do_op(fsq_pkg::OP_CHIP_ERASE, 20'h00000, 4);
    repeat (10) @(posedge clock_i);
    #1;
    check("refused", busy, 0);
    do_op(fsq_pkg::OP_CLEAR_LOCK, 20'h00000, 1);
    check("rd_status", st, 8'h80);
    @(posedge clock_i);
    req_i <= 1'b1;
    op_i <= fsq_pkg::OP_LOCK_BLOCK;
    @(posedge clock_i);
    req_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b1;
    @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    check("mid_reset", {busy, ack, ce_n, we_n, dq_oe}, 5'h06);
    do_op(fsq_pkg::OP_CLEAR_STAT, 20'h00000, 1);
    do_op(fsq_pkg::OP_READ_ARRAY, 20'h00000, 1);
    check("array_end", arr, 1);
    end_of_test();
  end
endmodule
